// *** include/lvictl_pkg.sv ***
// types shared by the supply monitor control logic
package lvictl_pkg;

    // configuration bits, msb first matches bit 3 down to bit 0
    typedef struct packed {
        logic trip_select_high;
        logic monitor_stop_enable;
        logic undervolt_reset_disable;
        logic monitor_power_down;
    } lvictl_cfg_type;

    // sticky event bits, msb first matches bit 2 down to bit 0
    typedef struct packed {
        logic lv_reset;
        logic flag_cleared;
        logic flag_set;
    } lvictl_event_type;

    // comparator results after synchronisation
    typedef struct packed {
        logic below_falling;
        logic above_rising;
    } lvictl_cmp_type;

    typedef enum logic [1:0] {
        LVICTL_RUN = 2'h0,
        LVICTL_HOLD = 2'h1
    } lvictl_state_type;

endpackage

// *** include/lvictl_regs.svh ***
// register map, field positions and reset values of the supply monitor
`ifndef LVICTL_REGS_SVH
`define LVICTL_REGS_SVH

`define LVICTL_ADDR_W 16
`define LVICTL_STATUS_OFS 16'hFE0C
`define LVICTL_CONFIG_OFS 16'hFE10
`define LVICTL_EVENT_OFS 16'hFE14
`define LVICTL_MASK_OFS 16'hFE18

`define LVICTL_STATUS_FLAG_BIT 7
`define LVICTL_CFG_PWRDN_BIT 0
`define LVICTL_CFG_RSTDIS_BIT 1
`define LVICTL_CFG_STOPEN_BIT 2
`define LVICTL_CFG_TRIPHI_BIT 3
`define LVICTL_CFG_W 4
`define LVICTL_EV_W 3
`define LVICTL_EV_SET_BIT 0
`define LVICTL_EV_CLR_BIT 1
`define LVICTL_EV_RST_BIT 2

`define LVICTL_CFG_RESET 4'h0
`define LVICTL_STATUS_RESET 8'h00
`define LVICTL_MASK_RESET 3'h0

`define LVICTL_RESP_OKAY 2'h0
`define LVICTL_RESP_SLVERR 2'h2

`endif

// *** rtl/lvictl_top.sv ***
// supply monitor control: hysteretic flag, low-voltage reset, axi4-lite registers
//
// Notes on behaviour
// [R1] monitor is enabled straight out of reset, no software needed
// [R2] monitor observes supply only while monitor power-down is clear
// [R3] reset-disable clear: supply below falling point forces system reset
// [R4] trip select 1 uses 5 V thresholds, 0 uses 3 V thresholds
// [R5] power-on reset returns trip select to 3 V; software reselects 5 V
// [R6] selecting 5 V while supply not above rising point enters reset at once
// [R7] low-voltage reset holds until supply rises above rising trip point
// [R8] comparator result drives the undervoltage flag in the status register
// [R9] low-voltage reset also pulls the external active-low reset pin low
// [R10] polled use: software keeps power-down 0, reset-disable 1, polls flag
// [R11] forced-reset use: software keeps power-down and reset-disable at 0
// [R12] status register: read-only flag in bit 7, other bits zero, writes ignored
// [R13] flag 0 above rising point, 1 below falling point, else unchanged
// [R14] any reset clears the undervoltage flag
// [R15] the monitor itself raises no interrupt request; here irq is raised by any unmasked sticky event
// [R16] enabled monitor stays active in wait mode; its reset ends wait mode
// [R17] monitor active in stop mode only with stop enable; its reset ends stop
// [R18] comparator outputs pass two flip-flops before use
`timescale 1ns/1ps
`include "lvictl_regs.svh"

module lvictl_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [`LVICTL_ADDR_W-1:0] s_awaddr,
    input wire logic [2:0] s_awprot,
    input wire logic s_awvalid,
    output logic s_awready,
    // axi4-lite write data
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // axi4-lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read address
    input wire logic [`LVICTL_ADDR_W-1:0] s_araddr,
    input wire logic [2:0] s_arprot,
    input wire logic s_arvalid,
    output logic s_arready,
    // axi4-lite read data
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // analog comparator, asynchronous
    input wire logic cmp_below_falling,
    input wire logic cmp_above_rising,
    output logic monitor_power_on,
    output logic trip_select_high,
    // low-power modes
    input wire logic wait_mode,
    input wire logic stop_mode,
    output logic wake_request,
    // system reset request and open-drain reset pin
    output logic lv_reset_request,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    // interrupt
    output logic irq
);

    lvictl_pkg::lvictl_cfg_type cfg_q;
    lvictl_pkg::lvictl_event_type event_q;
    lvictl_pkg::lvictl_event_type mask_q;
    lvictl_pkg::lvictl_event_type event_d;
    lvictl_pkg::lvictl_cmp_type cmp_meta_q;
    lvictl_pkg::lvictl_cmp_type cmp_q;
    lvictl_pkg::lvictl_state_type state_q;
    logic flag_q;
    logic mon_active;
    logic trip_raise;
    logic lv_trigger;
    logic [3:0] raise_dly_q;

    // axi slave state
    logic awready_q;
    logic wready_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic [`LVICTL_ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rd_pend_q;
    logic [`LVICTL_ADDR_W-1:0] araddr_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic do_write;
    logic do_read;
    logic wr_cfg;
    logic wr_mask;
    logic rd_event;

    // output flops
    logic mon_on_q;
    logic trip_hi_q;
    logic wake_q;
    logic lv_rst_q;
    logic pin_oe_n_q;
    logic irq_q;

    assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
    assign do_read = rd_pend_q && !rvalid_q;
    assign wr_cfg = do_write && (awaddr_q == `LVICTL_CONFIG_OFS) && wstrb_q[0];
    assign wr_mask = do_write && (awaddr_q == `LVICTL_MASK_OFS) && wstrb_q[0];
    assign rd_event = do_read && (araddr_q == `LVICTL_EVENT_OFS);

    // comparator synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_meta_q <= '0;
            cmp_q <= '0;
        end else begin
            cmp_meta_q <= {cmp_below_falling, cmp_above_rising}; // R18
            cmp_q <= cmp_meta_q; // R18
        end
    end

    // monitor sees the supply unless powered down or stopped without stop enable
    assign mon_active = !cfg_q.monitor_power_down // R2
        && (!stop_mode || cfg_q.monitor_stop_enable); // R16 R17

    // configuration register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= `LVICTL_CFG_RESET; // R1 R5
        end else if (wr_cfg) begin
            cfg_q <= wdata_q[`LVICTL_CFG_W-1:0];
        end
    end

    // 5 V chosen while supply not above its rising point
    assign trip_raise = wr_cfg && wdata_q[`LVICTL_CFG_TRIPHI_BIT]
        && !cfg_q.trip_select_high;
    assign lv_trigger = (mon_active && !cfg_q.undervolt_reset_disable
        && cmp_q.below_falling) // R3
        || (trip_raise && !wdata_q[`LVICTL_CFG_RSTDIS_BIT]
        && !wdata_q[`LVICTL_CFG_PWRDN_BIT] && !cmp_q.above_rising) // R6
        || (raise_dly_q[3] && mon_active && cfg_q.trip_select_high
        && !cfg_q.undervolt_reset_disable && !cmp_q.above_rising); // R6

    // second look once the comparator and synchroniser run on the 5 V points
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raise_dly_q <= '0;
        end else begin
            raise_dly_q <= {raise_dly_q[2:0], trip_raise}; // R6
        end
    end

    // hysteretic undervoltage flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= 1'b0; // R14
        end else if (mon_active) begin
            if (cmp_q.below_falling) begin
                flag_q <= 1'b1; // R8 R13
            end else if (cmp_q.above_rising) begin
                flag_q <= 1'b0; // R13
            end
        end
    end

    // low-voltage reset hold
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= lvictl_pkg::LVICTL_RUN;
        end else begin
            case (state_q)
                lvictl_pkg::LVICTL_RUN: begin
                    if (lv_trigger) begin
                        state_q <= lvictl_pkg::LVICTL_HOLD; // R3 R6
                    end
                end
                lvictl_pkg::LVICTL_HOLD: begin
                    if (cmp_q.above_rising && !cmp_q.below_falling) begin
                        state_q <= lvictl_pkg::LVICTL_RUN; // R7
                    end
                end
                default: begin
                    state_q <= lvictl_pkg::LVICTL_RUN;
                end
            endcase
        end
    end

    // outputs to the analog side, reset controller and pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mon_on_q <= 1'b0;
            trip_hi_q <= 1'b0;
            lv_rst_q <= 1'b0;
            pin_oe_n_q <= 1'b1;
            wake_q <= 1'b0;
        end else begin
            mon_on_q <= mon_active; // R2
            trip_hi_q <= cfg_q.trip_select_high; // R4
            lv_rst_q <= (state_q == lvictl_pkg::LVICTL_HOLD);
            pin_oe_n_q <= !lv_rst_q; // R9
            wake_q <= (state_q == lvictl_pkg::LVICTL_HOLD) && !lv_rst_q
                && (wait_mode || stop_mode); // R16 R17
        end
    end

    // sticky events, a set in the clearing read wins
    always_comb begin
        event_d = event_q;
        if (rd_event) begin
            event_d = '0;
        end
        if (mon_active && cmp_q.below_falling && !flag_q) begin
            event_d.flag_set = 1'b1;
        end
        if (mon_active && cmp_q.above_rising && !cmp_q.below_falling && flag_q) begin
            event_d.flag_cleared = 1'b1;
        end
        if (state_q == lvictl_pkg::LVICTL_RUN && lv_trigger) begin
            event_d.lv_reset = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_q <= '0;
        end else begin
            event_q <= event_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= `LVICTL_MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= wdata_q[`LVICTL_EV_W-1:0];
        end
    end

    // system interrupt only; masked off after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(event_q & mask_q); // R15
        end
    end

    // write address and data, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            aw_hold_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_hold_q <= 1'b1;
            awaddr_q <= s_awaddr;
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
        end else if (!aw_hold_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b0;
            w_hold_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_wvalid && wready_q) begin
            wready_q <= 1'b0;
            w_hold_q <= 1'b1;
            wdata_q <= s_wdata;
            wstrb_q <= s_wstrb;
        end else if (do_write) begin
            w_hold_q <= 1'b0;
        end else if (!w_hold_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    // write response; status writes are accepted and ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `LVICTL_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            if (awaddr_q == `LVICTL_STATUS_OFS) begin
                bresp_q <= `LVICTL_RESP_OKAY; // R12
            end else if (awaddr_q == `LVICTL_CONFIG_OFS) begin
                bresp_q <= `LVICTL_RESP_OKAY;
            end else if (awaddr_q == `LVICTL_EVENT_OFS) begin
                bresp_q <= `LVICTL_RESP_OKAY;
            end else if (awaddr_q == `LVICTL_MASK_OFS) begin
                bresp_q <= `LVICTL_RESP_OKAY;
            end else begin
                bresp_q <= `LVICTL_RESP_SLVERR;
            end
        end else if (bvalid_q && s_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rd_pend_q <= 1'b0;
            araddr_q <= '0;
        end else if (s_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rd_pend_q <= 1'b1;
            araddr_q <= s_araddr;
        end else if (do_read) begin
            rd_pend_q <= 1'b0;
        end else if (!rd_pend_q && !rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // read data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `LVICTL_RESP_OKAY;
        end else if (do_read) begin
            rvalid_q <= 1'b1;
            rresp_q <= `LVICTL_RESP_OKAY;
            rdata_q <= '0;
            if (araddr_q == `LVICTL_STATUS_OFS) begin
                rdata_q[`LVICTL_STATUS_FLAG_BIT] <= flag_q; // R12
            end else if (araddr_q == `LVICTL_CONFIG_OFS) begin
                rdata_q[`LVICTL_CFG_W-1:0] <= cfg_q;
            end else if (araddr_q == `LVICTL_EVENT_OFS) begin
                rdata_q[`LVICTL_EV_W-1:0] <= event_q;
            end else if (araddr_q == `LVICTL_MASK_OFS) begin
                rdata_q[`LVICTL_EV_W-1:0] <= mask_q;
            end else begin
                rresp_q <= `LVICTL_RESP_SLVERR;
            end
        end else if (rvalid_q && s_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_awready = awready_q;
    assign s_wready = wready_q;
    assign s_bvalid = bvalid_q;
    assign s_bresp = bresp_q;
    assign s_arready = arready_q;
    assign s_rvalid = rvalid_q;
    assign s_rdata = rdata_q;
    assign s_rresp = rresp_q;
    assign monitor_power_on = mon_on_q;
    assign trip_select_high = trip_hi_q;
    assign wake_request = wake_q;
    assign lv_reset_request = lv_rst_q;
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe_n = pin_oe_n_q;
    assign irq = irq_q;

    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_sel_high;
        wr_cfg && trip_raise && !cmp_q.above_rising
            && !wdata_q[`LVICTL_CFG_RSTDIS_BIT] && !wdata_q[`LVICTL_CFG_PWRDN_BIT];
    endsequence

    sequence s_reset_seen;
        ##1 (state_q == lvictl_pkg::LVICTL_HOLD) ##1 lv_rst_q ##1 !rst_pin_oe_n;
    endsequence

    a_flag_sets: assert property ( // R13
        mon_active && cmp_q.below_falling |=> flag_q)
        else $error("flag not set below falling point");
    a_flag_clears: assert property ( // R13
        mon_active && cmp_q.above_rising && !cmp_q.below_falling |=> !flag_q)
        else $error("flag not cleared above rising point");
    a_flag_between: assert property ( // R13
        !cmp_q.above_rising && !cmp_q.below_falling |=> $stable(flag_q))
        else $error("flag changed between trip points");
    a_reset_trigger: assert property ( // R3
        state_q == lvictl_pkg::LVICTL_RUN && mon_active
            && !cfg_q.undervolt_reset_disable && cmp_q.below_falling |-> s_reset_seen)
        else $error("undervoltage did not reach reset and pin");
    a_five_volt_entry: assert property ( // R6
        (state_q == lvictl_pkg::LVICTL_RUN) and s_sel_high |-> s_reset_seen)
        else $error("5 V selection below rising point did not reset");
    a_hold_until_rise: assert property ( // R7
        state_q == lvictl_pkg::LVICTL_HOLD && !cmp_q.above_rising
            |=> state_q == lvictl_pkg::LVICTL_HOLD)
        else $error("reset released before supply rose");
    a_status_read: assert property ( // R12
        do_read && araddr_q == `LVICTL_STATUS_OFS
            |=> rvalid_q && rdata_q == {24'h000000, $past(flag_q), 7'h00})
        else $error("status read shape wrong");
    a_stop_idle: assert property ( // R17
        stop_mode && !cfg_q.monitor_stop_enable |=> $stable(flag_q))
        else $error("monitor active in stop without enable");
    a_powered_down: assert property ( // R2
        cfg_q.monitor_power_down |=> $stable(flag_q) && !monitor_power_on)
        else $error("monitor observed supply while powered down");
    a_trip_follows: assert property ( // R4
        ##1 cfg_q.trip_select_high |=> trip_select_high)
        else $error("trip select not driven to comparator");

endmodule

// *** test/lvictl_supply_model.sv ***
// partner model: supply comparator with selectable trip points and pulled-up reset pin
`timescale 1ns/1ps
module lvictl_supply_model #(
    parameter int FALL_LO_MV = 2600,
    parameter int RISE_LO_MV = 2700,
    parameter int FALL_HI_MV = 4200,
    parameter int RISE_HI_MV = 4300
) (
    // supply level set by the bench, in millivolts
    input wire logic [15:0] supply_mv,
    // controls from the design
    input wire logic trip_select_high,
    input wire logic monitor_power_on,
    // comparator outputs
    output logic cmp_below_falling,
    output logic cmp_above_rising,
    // open-drain reset pin
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n,
    output logic rst_pin_in
);
    always_comb begin
        if (!monitor_power_on) begin
            cmp_below_falling = 1'b0;
            cmp_above_rising = 1'b0;
        end else if (trip_select_high) begin
            cmp_below_falling = supply_mv < FALL_HI_MV;
            cmp_above_rising = supply_mv > RISE_HI_MV;
        end else begin
            cmp_below_falling = supply_mv < FALL_LO_MV;
            cmp_above_rising = supply_mv > RISE_LO_MV;
        end
    end

    // pull-up holds the pin high when nobody drives it
    assign rst_pin_in = rst_pin_oe_n ? 1'b1 : rst_pin_out;
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the supply monitor control block
`timescale 1ns/1ps
`include "lvictl_regs.svh"
module tb_top;
    localparam logic [1:0] OK = `LVICTL_RESP_OKAY;
    localparam logic [1:0] ERR = `LVICTL_RESP_SLVERR;
    localparam logic [15:0] ST = `LVICTL_STATUS_OFS;
    localparam logic [15:0] CF = `LVICTL_CONFIG_OFS;
    localparam logic [15:0] EV = `LVICTL_EVENT_OFS;
    localparam logic [15:0] MK = `LVICTL_MASK_OFS;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [15:0] s_awaddr = 16'h0, s_araddr = 16'h0, supply_mv = 16'd5000;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    logic cmp_below_falling, cmp_above_rising, monitor_power_on, trip_select_high;
    logic wait_mode = 1'b0, stop_mode = 1'b0, wake_request, lv_reset_request;
    logic rst_pin_in, rst_pin_out, rst_pin_oe_n, irq;
    int bad_count = 0, checks_done = 0, wake_cnt = 0, w0;

    lvictl_top u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_awaddr(s_awaddr), .s_awprot(3'h0), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arprot(3'h0), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .cmp_below_falling(cmp_below_falling), .cmp_above_rising(cmp_above_rising),
        .monitor_power_on(monitor_power_on), .trip_select_high(trip_select_high),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .wake_request(wake_request),
        .lv_reset_request(lv_reset_request), .rst_pin_in(rst_pin_in),
        .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .irq(irq));

    lvictl_supply_model u_supply (.supply_mv(supply_mv), .trip_select_high(trip_select_high),
        .monitor_power_on(monitor_power_on), .cmp_below_falling(cmp_below_falling),
        .cmp_above_rising(cmp_above_rising), .rst_pin_out(rst_pin_out),
        .rst_pin_oe_n(rst_pin_oe_n), .rst_pin_in(rst_pin_in));

    initial begin
        forever #20 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        if (wake_request === 1'b1) wake_cnt <= wake_cnt + 1;
    end

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_up();
        bad_count++;
        $display("wrong value at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
        stop_test();
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
            if (s_bvalid === 1'b1) break;
            if (++n > 50) give_up();
        end
        s_bready <= 1'b0;
        check({30'h0, s_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
            if (s_rvalid === 1'b1) break;
            if (++n > 50) give_up();
        end
        s_rready <= 1'b0;
        check(s_rdata, ed);
        check({30'h0, s_rresp}, {30'h0, er});
    endtask

    // three edges through the synchroniser and flag, plus margin
    task automatic supply(input logic [15:0] mv);
        @(posedge aclk);
        supply_mv <= mv;
        repeat (6) @(posedge aclk);
    endtask

    task automatic wait_rst(input logic v);
        int n;
        for (n = 0; lv_reset_request !== v; n++) begin
            if (n > 30) give_up();
            @(posedge aclk);
        end
        check({31'h0, lv_reset_request}, {31'h0, v});
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, bad_count);
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ST, 32'h0, OK);
        rd(CF, 32'h0, OK);
        check(monitor_power_on, 1'b1);
        check(trip_select_high, 1'b0);
        check({rst_pin_oe_n, irq}, 2'b10);
        end_test("reset");
        wr(ST, 32'hFF, OK);
        rd(ST, 32'h0, OK);
        rd(16'hFE20, 32'h0, ERR);
        wr(16'hFE20, 32'h1, ERR);
        end_test("registers");
        wr(CF, 32'h2, OK);
        supply(16'd2000);
        check(irq, 1'b0);
        rd(ST, 32'h80, OK);
        check(lv_reset_request, 1'b0);
        supply(16'd2650);
        rd(ST, 32'h80, OK);
        wr(MK, 32'h7, OK);
        repeat (3) @(posedge aclk);
        check(irq, 1'b1);
        rd(EV, 32'h1, OK);
        repeat (3) @(posedge aclk);
        check(irq, 1'b0);
        supply(16'd5000);
        rd(ST, 32'h0, OK);
        rd(EV, 32'h2, OK);
        end_test("polled");
        wr(CF, 32'h0, OK);
        wait_mode <= 1'b1;
        w0 = wake_cnt;
        supply(16'd2000);
        wait_rst(1'b1);
        repeat (2) @(posedge aclk);
        check({rst_pin_in, rst_pin_oe_n}, 2'b00);
        check(wake_cnt - w0, 32'h1);
        supply(16'd2650);
        repeat (10) @(posedge aclk);
        check(lv_reset_request, 1'b1);
        supply(16'd5000);
        wait_rst(1'b0);
        wait_mode <= 1'b0;
        end_test("forced reset");
        wr(CF, 32'h1, OK);
        supply(16'd2000);
        check({monitor_power_on, lv_reset_request}, 2'b00);
        rd(ST, 32'h0, OK);
        supply(16'd5000);
        end_test("power down");
        wr(CF, 32'h0, OK);
        stop_mode <= 1'b1;
        supply(16'd2000);
        check({monitor_power_on, lv_reset_request}, 2'b00);
        supply(16'd5000);
        wr(CF, 32'h4, OK);
        w0 = wake_cnt;
        supply(16'd2000);
        wait_rst(1'b1);
        check(wake_cnt - w0, 32'h1);
        supply(16'd5000);
        wait_rst(1'b0);
        stop_mode <= 1'b0;
        end_test("stop");
        supply(16'd2650);
        wr(CF, 32'h8, OK);
        wait_rst(1'b1);
        supply(16'd5000);
        wait_rst(1'b0);
        wr(CF, 32'h0, OK);
        supply(16'd4250);
        wr(CF, 32'h8, OK);
        @(posedge aclk);
        check(trip_select_high, 1'b1);
        wait_rst(1'b1);
        supply(16'd5000);
        wait_rst(1'b0);
        wr(CF, 32'hA, OK);
        supply(16'd3500);
        rd(ST, 32'h80, OK);
        check(lv_reset_request, 1'b0);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ST, 32'h0, OK);
        rd(CF, 32'h0, OK);
        check(trip_select_high, 1'b0);
        end_test("trip select");
        stop_test();
    end
endmodule
